// ===== hw/wcbf_pkg.sv
// Purpose: Shared constants and carriers for the store write-combining block
// Assumes: Stores arrive as one quadword per cycle with byte enables
// Notes:   Line address excludes the 6-bit byte offset within a line
package wcbf_pkg;
  localparam int ADDR_W      = 40;
  localparam int LINE_BYTES  = 64;
  localparam int QW_BYTES    = 8;
  localparam int OFS_W       = $clog2(LINE_BYTES);
  localparam int QIX_W       = $clog2(LINE_BYTES / QW_BYTES);
  localparam int LA_W        = ADDR_W - OFS_W;
  localparam int WCB_ENTRIES = 4;
  localparam int CC_BYTES    = 4096;
  localparam int CC_WAYS     = 4;
  localparam int CC_LINES    = CC_BYTES / LINE_BYTES;
  localparam int CC_SETS     = CC_LINES / CC_WAYS;

  typedef enum logic [2:0] {
    MT_UNCACHED, MT_COMBINING, MT_WRITETHRU, MT_WRPROTECT, MT_WRITEBACK, MT_STREAM
  } wcbf_mtype_t;

  typedef struct packed {
    logic [LA_W-1:0]         line_addr;
    logic [QIX_W-1:0]        qix;
    logic [QW_BYTES-1:0]     be;
    logic [QW_BYTES*8-1:0]   data;
    wcbf_mtype_t             mtype;
  } wcbf_store_t;

  typedef struct packed {
    logic [LA_W-1:0]         line_addr;
    logic [LINE_BYTES-1:0]   be;
    logic [LINE_BYTES*8-1:0] data;
  } wcbf_line_t;

  localparam wcbf_line_t LINE_RST = '0;
endpackage : wcbf_pkg

// ===== hw/wcbf_top.sv
// Purpose: Store coalescing cache plus combine line buffer with ordered flush
// Assumes: Single clock; l2 and system ports use valid/ready handshakes
// Notes:   Streaming stores are routed to the combine line buffer
`timescale 1ns/1ps
module wcbf_top #(
  parameter int N = wcbf_pkg::WCB_ENTRIES
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  // Store request
  input  wire logic                 st_valid_i,
  input  wire wcbf_pkg::wcbf_store_t st_i,
  output logic                      st_ready_o,
  input  wire logic                 flush_i,
  // System write port
  output logic                      sys_valid_o,
  output wcbf_pkg::wcbf_line_t      sys_o,
  input  wire logic                 sys_ready_i,
  // Level-two cache write port
  output logic                      l2_valid_o,
  output wcbf_pkg::wcbf_line_t      l2_o,
  input  wire logic                 l2_ready_i
);
  import wcbf_pkg::*;
  localparam int RW = $clog2(N);
  localparam int SW = $clog2(CC_SETS);
  localparam int WW = $clog2(CC_WAYS);

  function automatic wcbf_line_t merge(input wcbf_line_t l, input wcbf_store_t s);
    wcbf_line_t r;
    r = l;
    r.line_addr = s.line_addr;
    for (int b = 0; b < QW_BYTES; b++) begin
      if (s.be[b]) begin
        r.data[(int'(s.qix) * QW_BYTES + b) * 8 +: 8] = s.data[b*8 +: 8];
        r.be[int'(s.qix) * QW_BYTES + b] = 1'b1;
      end
    end
    return r;
  endfunction : merge

  // Close every live entry whose age rank is at or below thr
  function automatic logic [N-1:0] close_upto(input logic [N-1:0] v,
                                              input logic [N-1:0][RW-1:0] rk,
                                              input logic [RW-1:0] thr);
    logic [N-1:0] m;
    m = '0;
    for (int j = 0; j < N; j++) begin
      m[j] = v[j] && (rk[j] <= thr);
    end
    return m;
  endfunction : close_upto

  // Combine line buffer state
  logic [N-1:0]          vld_q, vld_d, cls_q, cls_d;
  logic [N-1:0][RW-1:0]  rank_q, rank_d;
  wcbf_mtype_t           mt_q [N];
  wcbf_mtype_t           mt_d [N];
  wcbf_line_t            ln_q [N];
  wcbf_line_t            ln_d [N];
  logic                  sys_vld_q, sys_vld_d, l2_vld_q, l2_vld_d;
  wcbf_line_t            sys_q, sys_d, l2_q, l2_d;
  // Coalescing cache arrays; data is not reset, valid bits are
  logic [CC_WAYS-1:0]    cc_vld_q [CC_SETS];
  logic [LA_W-1:0]       cc_tag_q [CC_SETS][CC_WAYS];
  wcbf_line_t            cc_ln_q  [CC_SETS][CC_WAYS];
  logic [WW-1:0]         cc_vic_q [CC_SETS];
  logic                  cc_we;
  logic [SW-1:0]         cc_set;
  logic [WW-1:0]         cc_way;
  // Lookup results
  logic                  snd, hit, cc_hit, out_free, l2_free;
  logic [RW-1:0]         sidx, hidx, nrank, fidx;
  logic                  free_ok;
  wcbf_line_t            mrg;

  assign out_free    = !sys_vld_q || sys_ready_i;
  assign l2_free     = !l2_vld_q || l2_ready_i;
  assign sys_valid_o = sys_vld_q;
  assign sys_o       = sys_q;
  assign l2_valid_o  = l2_vld_q;
  assign l2_o        = l2_q;
  assign cc_set      = st_i.line_addr[SW-1:0];

  always_comb begin
    vld_d = vld_q; cls_d = cls_q; rank_d = rank_q;
    mt_d = mt_q; ln_d = ln_q;
    sys_vld_d = sys_vld_q && !sys_ready_i; sys_d = sys_q;
    l2_vld_d = l2_vld_q && !l2_ready_i; l2_d = l2_q;
    st_ready_o = 1'b0; cc_we = 1'b0; cc_way = '0; cc_hit = 1'b0;
    snd = 1'b0; sidx = '0; hit = 1'b0; hidx = '0; free_ok = 1'b0; fidx = '0;
    nrank = '0; mrg = LINE_RST;
    // Only the oldest entry may leave, and only once closed
    for (int i = 0; i < N; i++) begin
      if (vld_q[i] && cls_q[i] && rank_q[i] == '0) begin
        snd = out_free;
        sidx = RW'(i);
      end
    end
    if (snd) begin
      sys_vld_d = 1'b1;
      sys_d = ln_q[sidx];
      vld_d[sidx] = 1'b0;
      cls_d[sidx] = 1'b0;
      for (int j = 0; j < N; j++) begin
        if (vld_q[j] && rank_q[j] != '0) rank_d[j] = rank_q[j] - 1'b1;
      end
    end
    for (int i = 0; i < N; i++) begin
      if (vld_q[i] && ln_q[i].line_addr == st_i.line_addr) begin
        hit = 1'b1;
        hidx = RW'(i);
      end
      if (!vld_d[i]) begin
        free_ok = 1'b1;
        fidx = RW'(i);
      end
      if (vld_d[i]) nrank = nrank + 1'b1;
    end
    if (flush_i) cls_d = cls_d | vld_d;
    if (st_valid_i && st_i.mtype == MT_WRITEBACK) begin
      if (vld_q != '0 || sys_vld_q) begin
        cls_d = cls_d | vld_d;
      end else if (l2_free) begin
        st_ready_o = 1'b1;
        mrg = LINE_RST;
        cc_way = cc_vic_q[cc_set];
        for (int w = 0; w < CC_WAYS; w++) begin
          if (cc_vld_q[cc_set][w] && cc_tag_q[cc_set][w] == st_i.line_addr) begin
            cc_hit = 1'b1;
            cc_way = WW'(w);
          end
        end
        if (cc_hit) mrg = cc_ln_q[cc_set][cc_way];
        mrg = merge(mrg, st_i);
        cc_we = 1'b1;
        l2_vld_d = 1'b1;
        l2_d = mrg;
      end
    end else if (st_valid_i) begin
      if (hit && (cls_q[hidx] || mt_q[hidx] != st_i.mtype)) begin
        cls_d = cls_d | close_upto(vld_d, rank_q, rank_q[hidx]);
      end else if (hit) begin
        st_ready_o = 1'b1;
        ln_d[hidx] = merge(ln_q[hidx], st_i);
        if (&ln_d[hidx].be) begin
          cls_d = cls_d | close_upto(vld_d, rank_q, rank_q[hidx]);
        end
      end else if (free_ok) begin
        st_ready_o = 1'b1;
        vld_d[fidx] = 1'b1;
        cls_d[fidx] = 1'b0;
        rank_d[fidx] = nrank;
        mt_d[fidx] = st_i.mtype;
        ln_d[fidx] = merge(LINE_RST, st_i);
      end else begin
        // All entries busy: retire the oldest stream to make room
        cls_d = cls_d | close_upto(vld_d, rank_q, '0);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      vld_q <= '0; cls_q <= '0; rank_q <= '0;
      sys_vld_q <= 1'b0; sys_q <= LINE_RST;
      l2_vld_q <= 1'b0; l2_q <= LINE_RST;
      for (int i = 0; i < N; i++) begin
        mt_q[i] <= MT_UNCACHED;
        ln_q[i] <= LINE_RST;
      end
      for (int s = 0; s < CC_SETS; s++) begin
        cc_vld_q[s] <= '0;
        cc_vic_q[s] <= '0;
      end
    end else begin
      vld_q <= vld_d; cls_q <= cls_d; rank_q <= rank_d;
      sys_vld_q <= sys_vld_d; sys_q <= sys_d;
      l2_vld_q <= l2_vld_d; l2_q <= l2_d;
      mt_q <= mt_d; ln_q <= ln_d;
      if (cc_we) begin
        cc_vld_q[cc_set][cc_way] <= 1'b1;
        if (!cc_hit) cc_vic_q[cc_set] <= cc_vic_q[cc_set] + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (cc_we) begin
      cc_tag_q[cc_set][cc_way] <= st_i.line_addr;
      cc_ln_q[cc_set][cc_way] <= mrg;
    end
  end

  // Checking helpers
  logic st_fire, full_open, older_open, rank_dup;
  assign st_fire = st_valid_i && st_ready_o;
  always_comb begin
    full_open = 1'b0; older_open = 1'b0; rank_dup = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (vld_q[i] && &ln_q[i].be && !cls_q[i]) full_open = 1'b1;
      for (int j = 0; j < N; j++) begin
        if (vld_q[i] && vld_q[j] && cls_q[i] && !cls_q[j] && rank_q[j] < rank_q[i])
          older_open = 1'b1;
        if (i != j && vld_q[i] && vld_q[j] && rank_q[i] == rank_q[j]) rank_dup = 1'b1;
      end
    end
  end

  sequence s_sys_stall;
    sys_valid_o && !sys_ready_i;
  endsequence
  sequence s_l2_stall;
    l2_valid_o && !l2_ready_i;
  endsequence

  property p_wb_drained;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_fire && st_i.mtype == MT_WRITEBACK) |-> (vld_q == '0 && !sys_valid_o);
  endproperty
  a_wb_drained: assert property (p_wb_drained) else $error("wb store passed buffers");

  property p_wb_to_l2;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_fire && st_i.mtype == MT_WRITEBACK) |=>
        (l2_valid_o && l2_o.line_addr == $past(st_i.line_addr));
  endproperty
  a_wb_to_l2: assert property (p_wb_to_l2) else $error("wb store missing on l2 port");

  property p_other_in_buf;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_fire && st_i.mtype != MT_WRITEBACK) |=> (vld_q != '0 && !$rose(l2_valid_o));
  endproperty
  a_other_in_buf: assert property (p_other_in_buf) else $error("bypass store misrouted");

  property p_full_closed;
    @(posedge mclk_i) disable iff (!rst_n_i) !full_open;
  endproperty
  a_full_closed: assert property (p_full_closed) else $error("full buffer left open");

  property p_older_closed;
    @(posedge mclk_i) disable iff (!rst_n_i) !older_open;
  endproperty
  a_older_closed: assert property (p_older_closed) else $error("older buffer still open");

  property p_rank_unique;
    @(posedge mclk_i) disable iff (!rst_n_i) !rank_dup;
  endproperty
  a_rank_unique: assert property (p_rank_unique) else $error("age ranks collide");

  property p_flush_closes;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (flush_i && !st_valid_i) |=> ((cls_q | ~vld_q) == '1);
  endproperty
  a_flush_closes: assert property (p_flush_closes) else $error("flush left one open");

  property p_sys_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
      s_sys_stall |=> (sys_valid_o && $stable(sys_o));
  endproperty
  a_sys_hold: assert property (p_sys_hold) else $error("sys write changed in stall");

  property p_l2_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
      s_l2_stall |=> (l2_valid_o && $stable(l2_o));
  endproperty
  a_l2_hold: assert property (p_l2_hold) else $error("l2 write changed under stall");
endmodule : wcbf_top

// ===== dv/wcbf_bridge.sv
// Purpose: Tunnel bridge model that takes line writes from the core
// Assumes: One line per handshake, far side shares the core clock
// Notes:   Ready stalls at random so held outputs get exercised
`timescale 1ns/1ps
module wcbf_bridge (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  // Line writes from the core
  input  wire logic                 sys_valid_i,
  input  wire wcbf_pkg::wcbf_line_t sys_i,
  output logic                      sys_ready_o,
  // Burst count on the downstream bus
  output int                        bursts_o
);
  import wcbf_pkg::*;
  logic [LA_W-1:0] last_q;
  logic            chain;
  assign chain = (bursts_o != 0) && (sys_i.line_addr == last_q + 1'b1);
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bursts_o <= 0;
      last_q   <= '0;
    end else if (sys_valid_i && sys_ready_o) begin
      // Only an ascending neighbour chains; a new burst costs one address phase
      if (!chain) bursts_o <= bursts_o + 1;
      last_q <= sys_i.line_addr;
    end
    sys_ready_o <= #1 ($urandom_range(3) != 0);
  end
endmodule : wcbf_bridge

// ===== dv/tb_write_combining_buffer_flush.sv
// Purpose: Self-checking bench for the store write-combining block
// Assumes: Bridge model stalls the system port, bench stalls the l2 port
// Notes:   Expected lines are queued by the driver and popped at each handshake
`timescale 1ns/1ps
module tb_write_combining_buffer_flush;
  import wcbf_pkg::*;
  localparam int W = $bits(wcbf_line_t);
  logic        mclk_i, rst_n_i, st_valid_i, st_ready_o, flush_i;
  logic        sys_valid_o, sys_ready_i, l2_valid_o, l2_ready_i;
  wcbf_store_t st_i;
  wcbf_line_t  sys_o, l2_o, cur, exp_q[$], l2_q[$];
  int          num_errors, n_compared, bursts, b0;
  wcbf_mtype_t tmt;

  wcbf_top wcbf_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .st_valid_i(st_valid_i),
    .st_i(st_i), .st_ready_o(st_ready_o), .flush_i(flush_i), .sys_valid_o(sys_valid_o),
    .sys_o(sys_o), .sys_ready_i(sys_ready_i), .l2_valid_o(l2_valid_o), .l2_o(l2_o),
    .l2_ready_i(l2_ready_i));
  wcbf_bridge wcbf_bridge_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sys_valid_i(sys_valid_o),
    .sys_i(sys_o), .sys_ready_o(sys_ready_i), .bursts_o(bursts));

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) l2_ready_i <= #1 1'($urandom_range(1));

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [W-1:0] got, input logic [W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check

  // Holds the store until taken; the caller lowers valid afterwards
  task automatic put(input logic [LA_W-1:0] la, input logic [2:0] q, input wcbf_mtype_t mt);
    logic [63:0] d;
    int          n;
    d = {$urandom, $urandom};
    st_i = '{la, q, 8'hFF, d, mt};
    st_valid_i = 1'b1;
    cur.line_addr = la;
    cur.be[q*8+:8] = 8'hFF;
    cur.data[q*64+:64] = d;
    n = 0;
    @(negedge mclk_i);
    while (st_ready_o !== 1'b1) begin
      n++;
      if (n > 300) begin
        num_errors++;
        wrap_up();
      end
      @(negedge mclk_i);
    end
    @(posedge mclk_i);
    #1;
  endtask : put

  task automatic drain(input logic pulse);
    int n;
    st_valid_i = 1'b0;
    flush_i = pulse;
    @(posedge mclk_i);
    #1;
    flush_i = 1'b0;
    for (n = 0; n < 600 && (exp_q.size() + l2_q.size()) > 0; n++) @(posedge mclk_i);
    if (n == 600) begin
      num_errors++;
      wrap_up();
    end
    #1;
  endtask : drain

  always @(posedge mclk_i) begin
    wcbf_line_t e, g;
    if (rst_n_i && sys_valid_o === 1'b1 && sys_ready_i === 1'b1) begin
      if (exp_q.size() == 0) check(W'(sys_o), ~W'(sys_o));
      else check(W'(sys_o), W'(exp_q.pop_front()));
    end
    if (rst_n_i && l2_valid_o === 1'b1 && l2_ready_i === 1'b1) begin
      check(W'(exp_q.size()), W'(0));
      e = (l2_q.size() > 0) ? l2_q.pop_front() : ~LINE_RST;
      g = l2_o;
      for (int k = 0; k < LINE_BYTES; k++) if (!e.be[k]) g.data[k*8+:8] = 8'h00;
      check(W'(g), W'(e));
    end
  end

  initial begin
    num_errors = 0;
    n_compared = 0;
    void'($urandom(22702));
    rst_n_i = 1'b0;
    st_valid_i = 1'b0;
    flush_i = 1'b0;
    st_i = '0;
    repeat (16) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    // Eight back-to-back quadwords fill a line, which leaves without a flush
    b0 = bursts;
    cur = LINE_RST;
    for (int q = 0; q < 8; q++) put(34'h10, 3'(q), MT_COMBINING);
    exp_q.push_back(cur);
    drain(1'b0);
    check(W'(bursts - b0), W'(1));
    $display("test full_line done");
    // Higher line opened first must still leave first; bridge cannot chain them
    b0 = bursts;
    cur = LINE_RST;
    put(34'h41, 3'h0, MT_COMBINING);
    exp_q.push_back(cur);
    cur = LINE_RST;
    put(34'h40, 3'h5, MT_STREAM);
    exp_q.push_back(cur);
    drain(1'b1);
    check(W'(bursts - b0), W'(2));
    $display("test open_order done");
    // Different type on an open line closes it before the new store combines
    cur = LINE_RST;
    put(34'h30, 3'h1, MT_COMBINING);
    exp_q.push_back(cur);
    cur = LINE_RST;
    tmt = wcbf_mtype_t'(3'($urandom_range(3)));
    if (tmt == MT_COMBINING) tmt = MT_UNCACHED;
    put(34'h30, 3'h1, tmt);
    exp_q.push_back(cur);
    drain(1'b1);
    $display("test type_change done");
    // Writeback store waits for the open buffer, then updates l2
    cur = LINE_RST;
    put(34'h50, 3'h7, MT_COMBINING);
    exp_q.push_back(cur);
    cur = LINE_RST;
    put(34'h22, 3'h2, MT_WRITEBACK);
    l2_q.push_back(cur);
    // Second store to the same line must merge with the cached copy
    put(34'h22, 3'h5, MT_WRITEBACK);
    l2_q.push_back(cur);
    drain(1'b0);
    $display("test writeback_order done");
    wrap_up();
  end
endmodule : tb_write_combining_buffer_flush
